/* core/rec_pkg.sv */
package rec_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    // Printed offsets are not all multiples of four: index, byte address is four times it
    localparam logic [3:0]  REC_IDX_IRQ_ENABLE_CLEAR = 4'h0;
    localparam logic [3:0]  REC_IDX_IRQ_ENABLE_SET   = 4'h1;
    localparam logic [3:0]  REC_IDX_IRQ_FLAGS        = 4'h2;
    localparam logic [3:0]  REC_IDX_STATUS           = 4'h3;
    localparam logic [3:0]  REC_IDX_ERROR_ADDRESS    = 4'h4;
    localparam logic [3:0]  REC_IDX_DEBUG_CONTROL    = 4'hF;
    localparam logic [3:0]  REC_IDX_WPROT            = 4'h8;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int          REC_BIT_SINGLE         = 0;
    localparam int          REC_BIT_DOUBLE         = 1;
    localparam int          REC_BIT_ECC_OFF        = 0;
    localparam int          REC_BIT_DBG_OFF        = 0;
    localparam int          REC_BIT_DBG_LOG        = 1;
    localparam int          REC_ADDR_W             = 17;
    localparam int          REC_DATA_W             = 32;
    localparam int          REC_CHK_W              = 5;
    localparam logic [1:0]  REC_IRQ_EN_RST         = 2'h0;
    localparam logic [1:0]  REC_DBG_RST            = 2'h0;
    localparam logic [16:0] REC_ERR_ADDR_RST       = 17'h0_0000;

    // Startup states: fuse load then run
    typedef enum logic [1:0] {
        REC_ST_LOAD = 2'b01,
        REC_ST_RUN  = 2'b10
    } rec_state_e;

    // One RAM access from a bus master
    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  from_debugger;
        logic [REC_ADDR_W-1:0] addr;
        logic [3:0]            strb;
        logic [31:0]           wdata;
    } rec_req_s;

    // Array side: data and check bits, one check code per byte
    typedef struct packed {
        logic [31:0]                    data;
        logic [4*REC_CHK_W-1:0]         chk;
    } rec_word_s;

    typedef struct packed {
        rec_state_e            state;
        logic                  ecc_off;
        logic                  wprot;
        logic [1:0]            irq_en;
        logic [1:0]            flags;
        logic [1:0]            dbg;
        logic [REC_ADDR_W-1:0] err_addr;
        logic                  rd_pend;
        logic                  rd_dbg;
        logic [REC_ADDR_W-1:0] rd_addr;
        logic [31:0]           rdata;
        logic                  rvalid;
    } rec_state_s;

endpackage : rec_pkg

/* core/rec_ram_error_corrector.sv */
`timescale 1ns/100ps
// What this block does
// - Each byte has its own code: correct one flipped bit, detect two.
// - A single-bit error found on a read sets the single-error flag, unless the same read also has a double-bit error.
// - A double-bit error found on a read sets the double-error flag.
// - First error captures the address; held until both flags are clear.
// - Double error while only single flag set overwrites the address.
// - Reading the error-address register clears both flags.
// - With ECC off, writes leave the stored check bits unchanged.
// - With ECC off, reads return raw data and set no flag.
// - Writing one to an enable-set bit enables it; zero does nothing.
// - Writing one to enable-clear disables it; both read shared state.
// - Interrupt asserts when a flag and its enable are both set.
// - Request holds until address read, disable, or reset.
// - All sources are ORed onto one request output.
// - Debug halt, logging 0, disable 0: debugger errors corrected, unflagged.
// - Debug halt, logging 1, disable 0: corrected and flagged.
// - Debug halt, disable 1: debugger reads neither corrected nor flagged.
// - Keeps working whenever its clock runs; interrupt can wake the system.
// - Optional write lock on all writable registers except flags and status.
// - Debugger register writes are never blocked by the lock.
// - With ECC on, the upper half of SRAM holds check codes.
// - ECC on or off comes from a fuse, not a software register.
// - Read-only ecc_off loaded from fuse at startup: one means disabled.
// - With ECC on, check bits are computed and stored on every write.
module rec_ram_error_corrector (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic                       pdebug,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       fuse_ecc_off,
    input  wire logic                       cpu_debug_halt,
    input  wire rec_pkg::rec_req_s          req,
    output logic      [31:0]                rsp_data,
    output logic                            rsp_valid,
    output logic                            ram_en,
    output logic                            ram_we,
    output logic      [rec_pkg::REC_ADDR_W-1:0] ram_addr,
    output logic      [3:0]                 ram_data_we,
    output logic      [3:0]                 ram_chk_we,
    output rec_pkg::rec_word_s              ram_wr,
    input  wire rec_pkg::rec_word_s         ram_rd,
    output logic                            ram_upper_reserved,
    output logic                            irq
);
    import rec_pkg::*;

    // ************************************************************
    // Byte check code: Hamming(12,8) plus overall parity
    // ************************************************************
    function automatic logic [4:0] rec_chk(input logic [7:0] d);
        logic [4:0] c;
        c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
        c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
        c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
        c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
        c[4] = ^d ^ c[0] ^ c[1] ^ c[2] ^ c[3];
        return c;
    endfunction : rec_chk

    // Position in the 12-bit code word of each data bit
    function automatic logic [3:0] rec_pos(input int i);
        logic [3:0] p;
        case (i)
            0: p = 4'h3;
            1: p = 4'h5;
            2: p = 4'h6;
            3: p = 4'h7;
            4: p = 4'h9;
            5: p = 4'hA;
            6: p = 4'hB;
            default: p = 4'hC;
        endcase
        return p;
    endfunction : rec_pos

    // ************************************************************
    // Fuse and debug-halt synchronisers
    // ************************************************************
    logic fuse_m;
    logic fuse_s;
    logic dbg_halt_m;
    logic dbg_halt_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_halt_m <= 1'b0;
            dbg_halt_s <= 1'b0;
        end else begin
            dbg_halt_m <= cpu_debug_halt;
            dbg_halt_s <= dbg_halt_m;
        end
    end

    // No reset: the fuse level must already fill both stages when reset lifts
    always_ff @(posedge pclk) begin
        fuse_m <= fuse_ecc_off;
        fuse_s <= fuse_m;
    end

    // ************************************************************
    // Read decode and correction
    // ************************************************************
    rec_state_s st;
    rec_state_s next_st;

    logic [31:0] corr_data;
    logic [3:0]  byte_single;
    logic [3:0]  byte_double;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++) begin : g_byte
            logic [7:0] d;
            logic [4:0] c;
            logic [4:0] k;
            logic [4:0] x;
            logic [7:0] q;
            assign d = ram_rd.data[8*gb +: 8];
            assign c = ram_rd.chk[REC_CHK_W*gb +: REC_CHK_W];
            assign k = rec_chk(d);
            // Syndrome below, parity of the whole stored code word on top
            assign x = {^{d, c}, k[3:0] ^ c[3:0]};
            assign byte_single[gb] = x[4];
            assign byte_double[gb] = !x[4] && (x[3:0] != 4'h0);
            always_comb begin
                q = d;
                for (int i = 0; i < 8; i++) begin
                    if (x[4] && x[3:0] == rec_pos(i)) begin
                        q[i] = !d[i];
                    end
                end
            end
            assign corr_data[8*gb +: 8] = q;
        end
    endgenerate

    // ************************************************************
    // APB decode
    // ************************************************************
    logic       apb_acc;
    logic       apb_wr;
    logic       apb_rd;
    logic [3:0] idx;
    logic       mapped;
    logic       wr_ok;

    assign idx     = paddr[5:2];
    assign apb_acc = psel && penable;
    assign mapped  = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0)
                     && (idx <= REC_IDX_ERROR_ADDRESS || idx == REC_IDX_DEBUG_CONTROL
                         || idx == REC_IDX_WPROT);
    assign apb_wr  = apb_acc && pwrite && mapped;
    assign apb_rd  = apb_acc && !pwrite && mapped;
    assign wr_ok   = !st.wprot || pdebug;
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !mapped;

    // ************************************************************
    // Next state
    // ************************************************************
    logic       rd_corr;
    logic       rd_log;
    logic       err_single;
    logic       err_double;
    logic       clr_read;

    always_comb begin
        next_st  = st;
        rd_corr  = 1'b1;
        rd_log   = 1'b1;
        if (st.rd_dbg && dbg_halt_s) begin
            rd_corr = !st.dbg[REC_BIT_DBG_OFF];
            rd_log  = st.dbg[REC_BIT_DBG_LOG] && !st.dbg[REC_BIT_DBG_OFF];
        end
        if (st.ecc_off) begin
            rd_corr = 1'b0;
            rd_log  = 1'b0;
        end
        err_double = st.rd_pend && rd_log && (|byte_double);
        err_single = st.rd_pend && rd_log && (|byte_single) && !err_double;
        clr_read   = apb_rd && idx == REC_IDX_ERROR_ADDRESS;

        case (st.state)
            REC_ST_LOAD: begin
                next_st.ecc_off = fuse_s;
                next_st.state   = REC_ST_RUN;
            end
            REC_ST_RUN: begin
                next_st.state = REC_ST_RUN;
            end
            default: next_st.state = REC_ST_LOAD;
        endcase

        if (clr_read) begin
            next_st.flags = 2'b00;
        end
        if (err_single) begin
            next_st.flags[REC_BIT_SINGLE] = 1'b1;
            if (st.flags == 2'b00 || clr_read) begin
                next_st.err_addr = st.rd_addr;
            end
        end
        if (err_double) begin
            next_st.flags[REC_BIT_DOUBLE] = 1'b1;
            if (!st.flags[REC_BIT_DOUBLE] || clr_read) begin
                next_st.err_addr = st.rd_addr;
            end
        end

        if (apb_wr && (wr_ok || idx == REC_IDX_IRQ_FLAGS)) begin
            case (idx)
                REC_IDX_IRQ_ENABLE_SET:   next_st.irq_en = st.irq_en | pwdata[1:0];
                REC_IDX_IRQ_ENABLE_CLEAR: next_st.irq_en = st.irq_en & ~pwdata[1:0];
                REC_IDX_DEBUG_CONTROL:    next_st.dbg    = pwdata[1:0];
                REC_IDX_WPROT:            next_st.wprot  = pwdata[0];
                default: ;
            endcase
        end

        next_st.rd_pend = req.valid && !req.write;
        next_st.rd_dbg  = req.from_debugger;
        next_st.rd_addr = req.addr;
        next_st.rvalid  = st.rd_pend;
        next_st.rdata   = rd_corr ? corr_data : ram_rd.data;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.state    <= REC_ST_LOAD;
            st.irq_en   <= REC_IRQ_EN_RST;
            st.dbg      <= REC_DBG_RST;
            st.err_addr <= REC_ERR_ADDR_RST;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Register read mux
    // ************************************************************
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_rd) begin
            case (idx)
                REC_IDX_IRQ_ENABLE_SET,
                REC_IDX_IRQ_ENABLE_CLEAR: prdata[1:0] = st.irq_en;
                REC_IDX_IRQ_FLAGS:        prdata[1:0] = st.flags;
                REC_IDX_STATUS:           prdata[0]   = st.ecc_off;
                REC_IDX_ERROR_ADDRESS:    prdata[REC_ADDR_W-1:0] = st.err_addr;
                REC_IDX_DEBUG_CONTROL:    prdata[1:0] = st.dbg;
                REC_IDX_WPROT:            prdata[0]   = st.wprot;
                default:                  prdata      = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // RAM side
    // ************************************************************
    always_comb begin
        ram_en      = req.valid;
        ram_we      = req.valid && req.write;
        ram_addr    = req.addr;
        ram_data_we = ram_we ? req.strb : 4'h0;
        ram_chk_we  = (ram_we && !st.ecc_off) ? req.strb : 4'h0;
        ram_wr.data = req.wdata;
        for (int b = 0; b < 4; b++) begin
            ram_wr.chk[REC_CHK_W*b +: REC_CHK_W] = rec_chk(req.wdata[8*b +: 8]);
        end
    end

    assign ram_upper_reserved = !st.ecc_off;
    assign rsp_data           = st.rdata;
    assign rsp_valid          = st.rvalid;
    // Level request; runs on pclk so it can wake the system while the clock runs
    assign irq = |(st.flags & st.irq_en);

    // ************************************************************
    // Checks
    // ************************************************************
    a_irq_follows_flags: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st.flags & st.irq_en)) else $error("irq does not match flags");
    a_clear_on_read: assert property (@(posedge pclk) disable iff (!presetn)
        clr_read && !err_single && !err_double |=> st.flags == 2'b00)
        else $error("flags not cleared by address read");
    a_single_sets: assert property (@(posedge pclk) disable iff (!presetn)
        err_single |=> st.flags[REC_BIT_SINGLE]) else $error("single flag not set");
    a_double_sets: assert property (@(posedge pclk) disable iff (!presetn)
        err_double |=> st.flags[REC_BIT_DOUBLE] && (st.err_addr == $past(st.rd_addr)
            || ($past(st.flags[REC_BIT_DOUBLE]) && !$past(clr_read) && $stable(st.err_addr))))
        else $error("double flag or address wrong");
    a_addr_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        st.flags != 2'b00 && !err_double && !clr_read |=> $stable(st.err_addr))
        else $error("address changed while frozen");
    a_enable_set: assert property (@(posedge pclk) disable iff (!presetn)
        apb_wr && wr_ok && idx == REC_IDX_IRQ_ENABLE_SET |=> (st.irq_en & $past(pwdata[1:0])) == $past(pwdata[1:0]))
        else $error("enable set failed");
    a_enable_clear: assert property (@(posedge pclk) disable iff (!presetn)
        apb_wr && wr_ok && idx == REC_IDX_IRQ_ENABLE_CLEAR |=> (st.irq_en & $past(pwdata[1:0])) == 2'b00)
        else $error("enable clear failed");
    a_off_no_chk: assert property (@(posedge pclk) disable iff (!presetn)
        st.ecc_off |-> ram_chk_we == 4'h0) else $error("check bits written while off");
    a_off_no_flag: assert property (@(posedge pclk) disable iff (!presetn)
        st.ecc_off && !clr_read |=> st.flags == $past(st.flags)) else $error("flag set while off");
    a_debug_lock: assert property (@(posedge pclk) disable iff (!presetn)
        apb_wr && pdebug && idx == REC_IDX_DEBUG_CONTROL |=> st.dbg == $past(pwdata[1:0]))
        else $error("debugger write blocked");

    // ************************************************************
    // Checks: interrupt request and write lock
    // ************************************************************
    a_irq_holds: assert property (@(posedge pclk) disable iff (!presetn)
        irq && !clr_read && !(apb_wr && wr_ok && idx == REC_IDX_IRQ_ENABLE_CLEAR) |=> irq)
        else $error("interrupt request dropped early");
    a_irq_drops: assert property (@(posedge pclk) disable iff (!presetn)
        clr_read && !err_single && !err_double |=> !irq)
        else $error("interrupt kept after address read");
    a_irq_any_source: assert property (@(posedge pclk) disable iff (!presetn)
        (st.flags[REC_BIT_SINGLE] && st.irq_en[REC_BIT_SINGLE])
        || (st.flags[REC_BIT_DOUBLE] && st.irq_en[REC_BIT_DOUBLE]) |-> irq)
        else $error("enabled source gives no request");
    a_lock_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        apb_wr && !wr_ok && idx == REC_IDX_IRQ_ENABLE_SET |=> $stable(st.irq_en))
        else $error("locked enable write took effect");
    a_lock_debugger: assert property (@(posedge pclk) disable iff (!presetn)
        apb_wr && pdebug && idx == REC_IDX_WPROT |=> st.wprot == $past(pwdata[0]))
        else $error("debugger lock write blocked");

    // ************************************************************
    // Checks: ECC off and debug policy
    // ************************************************************
    a_off_raw: assert property (@(posedge pclk) disable iff (!presetn)
        st.ecc_off && st.rd_pend |=> rsp_data == $past(ram_rd.data))
        else $error("read corrected while off");
    a_dbg_raw: assert property (@(posedge pclk) disable iff (!presetn)
        st.rd_pend && st.rd_dbg && dbg_halt_s && st.dbg[REC_BIT_DBG_OFF]
        |=> rsp_data == $past(ram_rd.data)) else $error("debugger read corrected");
    a_dbg_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        st.rd_pend && st.rd_dbg && dbg_halt_s && st.dbg != 2'b10 && !clr_read
        |=> st.flags == $past(st.flags)) else $error("debugger read logged");
    a_dbg_logs: assert property (@(posedge pclk) disable iff (!presetn)
        st.rd_pend && st.rd_dbg && dbg_halt_s && st.dbg == 2'b10 && !st.ecc_off
        && (|(byte_single | byte_double)) |=> st.flags != 2'b00)
        else $error("debugger read not logged");
    a_fuse_held: assert property (@(posedge pclk) disable iff (!presetn)
        st.state == REC_ST_RUN |=> $stable(st.ecc_off))
        else $error("ecc_off changed at run time");

    // ************************************************************
    // Checks: RAM side and first error address
    // ************************************************************
    a_chk_stored: assert property (@(posedge pclk) disable iff (!presetn)
        ram_we && !st.ecc_off |-> ram_chk_we == req.strb)
        else $error("check bits not stored");
    a_clean_pass: assert property (@(posedge pclk) disable iff (!presetn)
        st.rd_pend && byte_single == 4'h0 && byte_double == 4'h0
        |=> rsp_data == $past(ram_rd.data)) else $error("clean word altered");
    a_single_addr: assert property (@(posedge pclk) disable iff (!presetn)
        err_single && st.flags == 2'b00 |=> st.err_addr == $past(st.rd_addr))
        else $error("first error address not captured");

endmodule : rec_ram_error_corrector

/* testbench/rec_ram_error_corrector_bench.sv */
`timescale 1ns/100ps
module rec_ram_error_corrector_bench;
    import rec_pkg::*;
    localparam logic [11:0] A_CLR = {6'h00, REC_IDX_IRQ_ENABLE_CLEAR, 2'b00};
    localparam logic [11:0] A_SET = {6'h00, REC_IDX_IRQ_ENABLE_SET, 2'b00};
    localparam logic [11:0] A_FLG = {6'h00, REC_IDX_IRQ_FLAGS, 2'b00};
    localparam logic [11:0] A_STA = {6'h00, REC_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_ERR = {6'h00, REC_IDX_ERROR_ADDRESS, 2'b00};
    localparam logic [11:0] A_DBG = {6'h00, REC_IDX_DEBUG_CONTROL, 2'b00};
    localparam logic [11:0] A_LCK = {6'h00, REC_IDX_WPROT, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pdebug, pready, pslverr, er;
    logic        fuse_ecc_off, cpu_debug_halt, rsp_valid, ram_en, ram_we, irq;
    logic        ram_upper_reserved;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rsp_data, flip, rd, seed, d0, f1;
    logic [16:0] ram_addr, a0, a1;
    logic [3:0]  ram_data_we, ram_chk_we, wchk;
    rec_req_s    req;
    rec_word_s   ram_wr, ram_rd;
    int          n_fail, comparisons;

    rec_ram_error_corrector rec_ram_error_corrector_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pdebug, .prdata,
        .pready, .pslverr, .fuse_ecc_off, .cpu_debug_halt, .req, .rsp_data, .rsp_valid,
        .ram_en, .ram_we, .ram_addr, .ram_data_we, .ram_chk_we, .ram_wr, .ram_rd,
        .ram_upper_reserved, .irq
    );
    rec_ram_model rec_ram_model_inst (
        .pclk, .ram_en, .ram_we, .ram_addr, .ram_data_we, .ram_chk_we, .ram_wr, .flip,
        .ram_rd
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic dbg);
        logic rdy;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pdebug  <= dbg;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = pready;
            rd  = prdata;
            er  = pslverr;
        end while (rdy !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b0);
        check(rd, exp);
    endtask : rchk

    // Read data counts only in the cycle that the response is flagged valid
    task automatic ram(input logic w, input logic [16:0] a, input logic [31:0] d,
                       input logic dbg, input logic [31:0] f);
        req  <= '{1'b1, w, dbg, a, 4'hf, d};
        flip <= f;
        @(negedge pclk);
        wchk = ram_chk_we;
        @(posedge pclk);
        req.valid <= 1'b0;
        if (!w) begin
            @(posedge pclk);
            @(negedge pclk);
            rd = (rsp_valid === 1'b1) ? rsp_data : ~rsp_data;
        end
        @(posedge pclk);
    endtask : ram

    task automatic do_reset(input logic f);
        presetn      <= 1'b0;
        fuse_ecc_off <= f;
        repeat (4) @(posedge pclk);
        presetn      <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask : do_reset

    // ************************************************************
    // Clock, watchdog and test sequence
    // ************************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        #400000;
        n_fail++;
        end_sim();
    end

    initial begin
        {psel, penable, pwrite, pdebug, cpu_debug_halt, presetn, fuse_ecc_off} = '0;
        {paddr, pwdata, req, flip, n_fail, comparisons} = '0;
        seed = 32'h0000_b665;
        @(posedge pclk);
        do_reset(1'b0);
        check({31'h0, ram_upper_reserved}, 32'h1);
        rchk(A_STA, 32'h0);
        rchk(A_FLG, 32'h0);
        rchk(A_ERR, 32'h0);
        apb(1'b0, 12'h018, 32'h0, 1'b0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, A_SET, 32'h3, 1'b0);
        rchk(A_CLR, 32'h3);
        apb(1'b1, A_CLR, 32'h1, 1'b0);
        apb(1'b1, A_SET, 32'h0, 1'b0);
        rchk(A_SET, 32'h2);
        rchk(A_CLR, 32'h2);
        apb(1'b1, A_SET, 32'h1, 1'b0);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            a0   = {1'b0, seed[15:2], 2'b00};
            a1   = a0 ^ 17'h0_4000;
            f1   = 32'h1 << seed[20:16];
            d0   = lfsr(seed);
            ram(1'b1, a0, d0, 1'b0, 32'h0);
            check({28'h0, wchk}, 32'hf);
            ram(1'b1, a1, d0, 1'b0, 32'h0);
            ram(1'b0, a0, 32'h0, 1'b0, f1);
            check(rd, d0);
            check({31'h0, irq}, 32'h1);
            ram(1'b0, a1, 32'h0, 1'b0, f1);
            check(rd, d0);
            rchk(A_FLG, 32'h1);
            rchk(A_ERR, {15'h0, a0});
            rchk(A_FLG, 32'h0);
            ram(1'b0, a0, 32'h0, 1'b0, f1);
            ram(1'b0, a1, 32'h0, 1'b0, 32'h0000_0011 << (8 * seed[17:16]));
            rchk(A_FLG, 32'h3);
            rchk(A_ERR, {15'h0, a1});
            check({31'h0, irq}, 32'h0);
        end
        ram(1'b0, a0, 32'h0, 1'b0, 32'h0);
        check(rd, d0);
        ram(1'b0, a1, 32'h0, 1'b0, 32'h0000_0011);
        // Clearing read and a new single error land on the same edge
        fork
            ram(1'b0, a0, 32'h0, 1'b0, f1);
            apb(1'b0, A_ERR, 32'h0, 1'b0);
        join
        rchk(A_FLG, 32'h1);
        rchk(A_ERR, {15'h0, a0});
        ram(1'b0, a0, 32'h0, 1'b0, f1);
        apb(1'b1, A_CLR, 32'h3, 1'b0);
        check({31'h0, irq}, 32'h0);
        rchk(A_FLG, 32'h1);
        apb(1'b0, A_ERR, 32'h0, 1'b0);
        cpu_debug_halt <= 1'b1;
        repeat (3) @(posedge pclk);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, A_DBG, m, 1'b0);
            ram(1'b0, a0, 32'h0, 1'b1, 32'h0000_0100);
            check(rd, m[0] ? d0 ^ 32'h0000_0100 : d0);
            rchk(A_FLG, (m == 2) ? 32'h1 : 32'h0);
            apb(1'b0, A_ERR, 32'h0, 1'b0);
        end
        cpu_debug_halt <= 1'b0;
        apb(1'b1, A_LCK, 32'h1, 1'b0);
        apb(1'b1, A_SET, 32'h3, 1'b0);
        rchk(A_SET, 32'h0);
        apb(1'b1, A_SET, 32'h3, 1'b1);
        rchk(A_SET, 32'h3);
        apb(1'b1, A_LCK, 32'h0, 1'b1);
        do_reset(1'b1);
        rchk(A_STA, 32'h1);
        check({31'h0, ram_upper_reserved}, 32'h0);
        ram(1'b1, a0, d0, 1'b0, 32'h0);
        check({28'h0, wchk}, 32'h0);
        ram(1'b0, a0, 32'h0, 1'b0, 32'h0000_0001);
        check(rd, d0 ^ 32'h0000_0001);
        rchk(A_FLG, 32'h0);
        end_sim();
    end
endmodule : rec_ram_error_corrector_bench

/* testbench/rec_ram_model.sv */
`timescale 1ns/100ps
module rec_ram_model
    import rec_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              ram_en,
    input  wire logic              ram_we,
    input  wire logic [16:0]       ram_addr,
    input  wire logic [3:0]        ram_data_we,
    input  wire logic [3:0]        ram_chk_we,
    input  wire rec_pkg::rec_word_s ram_wr,
    input  wire logic [31:0]       flip,
    output rec_pkg::rec_word_s     ram_rd
);
    rec_word_s mem [int];
    rec_word_s w;

    initial ram_rd = '0;

    // ************************************************************
    // Synchronous array, byte lanes and check lanes written apart
    // ************************************************************
    always @(posedge pclk) begin
        w = mem.exists(int'(ram_addr)) ? mem[int'(ram_addr)] : '0;
        if (ram_en && ram_we) begin
            for (int b = 0; b < 4; b++) begin
                if (ram_data_we[b]) w.data[8*b+:8] = ram_wr.data[8*b+:8];
                if (ram_chk_we[b]) w.chk[5*b+:5] = ram_wr.chk[5*b+:5];
            end
            mem[int'(ram_addr)] = w;
        end
        // Injected upsets apply to the data on the way out only
        w.data = w.data ^ flip;
        // Outside the answer cycle the port shows a changing value
        ram_rd <= (ram_en && !ram_we) ? w : ~ram_rd;
    end
endmodule : rec_ram_model
